// [pwrseq_asserts.sv]
// Purpose: assertions on the power and reset pins between host and module
// Assumes: one clock; long counts shortened by parameters
// Notes: instantiated beside the interface that joins the two ends
`timescale 1ns/1ps
`default_nettype none
module pwrseq_asserts #(
  parameter int unsigned BOOT_MAX_CYC = 60,
  parameter int unsigned OFF_SEQ_CYC = 20,
  parameter int unsigned EMERG_CYC = 30,
  parameter int unsigned PRESS_CYC = 10,
  parameter int unsigned QUIET_CYC = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host to module
  input wire logic power_on_req_n,
  input wire logic reset_req_n,
  input wire logic powerdown_command,
  input wire logic baseband_battery_supply,
  // module to host
  input wire logic io_supply_indicator,
  input wire logic usb_enum_start
);
  localparam int BOOT_LIM = BOOT_MAX_CYC + 8;
  localparam int OFF_LIM = OFF_SEQ_CYC + 8;
  logic [31:0] rst_low_reg, rst_low_next, pon_low_reg, pon_low_next, on_reg, on_next;

  // lengths of low request levels and time since supply on
  always_comb begin
    rst_low_next = reset_req_n ? 32'h0 : rst_low_reg + 32'h1;
    pon_low_next = power_on_req_n ? 32'h0 : pon_low_reg + 32'h1;
    on_next = baseband_battery_supply ? on_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_low_reg <= 32'h0;
      pon_low_reg <= 32'h0;
      on_reg <= 32'h0;
    end else begin
      rst_low_reg <= rst_low_next;
      pon_low_reg <= pon_low_next;
      on_reg <= on_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // steps of boot, shutdown and restart
  sequence s_boot_start;
    $fell(power_on_req_n) && baseband_battery_supply && !io_supply_indicator;
  endsequence
  sequence s_ind_drop;
    ##[1:OFF_LIM] !io_supply_indicator;
  endsequence
  sequence s_ind_back;
    ##[1:BOOT_LIM] io_supply_indicator;
  endsequence

  a_boot_ind_rise: assert property (s_boot_start |-> s_ind_back)
    else $error("indicator did not rise after power-on request");
  a_no_early_ind: assert property (s_boot_start |-> !io_supply_indicator [*8])
    else $error("indicator rose too early in boot");
  a_enum_with_ind: assert property ($rose(io_supply_indicator) |->
      usb_enum_start || $past(usb_enum_start))
    else $error("enumeration start missing at boot end");
  a_enum_one_cycle: assert property (usb_enum_start |=> !usb_enum_start)
    else $error("enumeration start longer than one cycle");
  a_pd_turns_off: assert property ($rose(powerdown_command) && power_on_req_n &&
      io_supply_indicator |-> s_ind_drop)
    else $error("indicator stayed high after powerdown");
  a_pd_restarts: assert property ($rose(powerdown_command) && !power_on_req_n &&
      io_supply_indicator |-> s_ind_drop ##0 s_ind_back)
    else $error("no restart after powerdown with request held");
  a_reset_drops_ind: assert property ($fell(reset_req_n) && io_supply_indicator |->
      ##[1:6] !io_supply_indicator)
    else $error("indicator stayed high in reset");
  a_emerg_stays_off: assert property ($rose(reset_req_n) && power_on_req_n &&
      rst_low_reg >= EMERG_CYC |-> not s_ind_back)
    else $error("module came back after emergency off");
  a_press_long_enough: assert property ($rose(power_on_req_n) |->
      pon_low_reg >= PRESS_CYC)
    else $error("power-on request released too soon");
  a_host_quiet_first: assert property ($rose(powerdown_command) || $fell(reset_req_n) |->
      on_reg > QUIET_CYC)
    else $error("host drove pins in quiet period");
  a_supply_after_off: assert property ($fell(baseband_battery_supply) |->
      !io_supply_indicator)
    else $error("supply removed while indicator high");
endmodule
`default_nettype wire

// [pwrseq_device.sv]
// Purpose: module-side power on/off, reset and emergency-off sequencer
// Assumes: host holds pins as its own timing asks; pins are synchronised here
// Notes: counts are parameters so simulation can shorten them
// Notes: a long reset powers off only with the request released; held, it resets
`timescale 1ns/1ps
`default_nettype none
module pwrseq_device #(
  parameter int unsigned BOOT_CYC = pwrseq_pkg::PWR_ON_TYP_CYC,
  parameter int unsigned BOOT_MAX_CYC = pwrseq_pkg::PWR_ON_MAX_CYC,
  parameter int unsigned EMERG_CYC = pwrseq_pkg::EMERG_OFF_CYC,
  parameter int unsigned OFF_SEQ_CYC = pwrseq_pkg::PWR_OFF_MAX_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins toward the host
  pwrseq_if.device pins,
  // user side status
  output logic active,
  output logic booting
);
  // two-flop synchronisers for pins
  logic [3:0] sync1_reg, sync2_reg;
  logic [3:0] sync1_next, sync2_next;
  logic pon_n_s, rst_req_n_s, pd_cmd_s, supply_s;

  always_comb begin
    sync1_next = {pins.baseband_battery_supply, pins.powerdown_command,
                  pins.reset_req_n, pins.power_on_req_n};
    sync2_next = sync1_reg;
  end

  // sync stages start at the idle pin levels, supply absent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= pwrseq_pkg::PIN_IDLE;
      sync2_reg <= pwrseq_pkg::PIN_IDLE;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign pon_n_s = sync2_reg[0];
  assign rst_req_n_s = sync2_reg[1];
  assign pd_cmd_s = sync2_reg[2];
  assign supply_s = sync2_reg[3];

  // sequencer state, counters and outputs
  pwrseq_pkg::dev_state_t state_reg, state_next;
  logic [pwrseq_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [pwrseq_pkg::CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic restart_reg, restart_next;
  logic ind_reg, ind_next;
  logic enum_reg, enum_next;
  logic pd_prev_reg, pd_prev_next;
  logic pd_pulse;

  // reset request low time, saturating at the emergency count
  always_comb begin
    rst_cnt_next = '0;
    if (!rst_req_n_s) begin
      if (rst_cnt_reg != pwrseq_pkg::CNT_W'(EMERG_CYC)) begin
        rst_cnt_next = rst_cnt_reg + 1'b1;
      end else begin
        rst_cnt_next = rst_cnt_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_reg <= '0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // last command level for edge detection; idle level is low
  always_comb begin
    pd_prev_next = pd_cmd_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_prev_reg <= 1'b0;
    end else begin
      pd_prev_reg <= pd_prev_next;
    end
  end

  // one-cycle strobe on the command's rising edge
  assign pd_pulse = pd_cmd_s & ~pd_prev_reg;

  // sequencer next state, counter and outputs
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    restart_next = restart_reg;
    ind_next = ind_reg;
    enum_next = 1'b0;
    unique case (state_reg)
      pwrseq_pkg::DEV_OFF: begin
        ind_next = 1'b0;
        cnt_next = '0;
        if (supply_s && !pon_n_s && rst_req_n_s) begin
          state_next = pwrseq_pkg::DEV_BOOT;
        end
      end
      pwrseq_pkg::DEV_BOOT: begin
        cnt_next = cnt_reg + 1'b1;
        // the shorter of typical and maximum ends boot
        // boot bounded, enumeration start
        if (cnt_reg >= pwrseq_pkg::CNT_W'(BOOT_CYC - 1) ||
            cnt_reg >= pwrseq_pkg::CNT_W'(BOOT_MAX_CYC - 1)) begin
          state_next = pwrseq_pkg::DEV_ACTIVE;
          ind_next = 1'b1;
          enum_next = 1'b1;
          cnt_next = '0;
        end
      end
      pwrseq_pkg::DEV_ACTIVE: begin
        ind_next = 1'b1;
        // request level at command time picks restart
        // powerdown restart or off
        if (pd_pulse) begin
          restart_next = ~pon_n_s;
          state_next = pwrseq_pkg::DEV_SHUTDOWN;
          cnt_next = '0;
        end
      end
      pwrseq_pkg::DEV_SHUTDOWN: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= pwrseq_pkg::CNT_W'(OFF_SEQ_CYC - 1)) begin
          ind_next = 1'b0;
          cnt_next = '0;
          state_next = restart_reg ? pwrseq_pkg::DEV_BOOT : pwrseq_pkg::DEV_OFF;
        end
      end
      pwrseq_pkg::DEV_RESET: begin
        ind_next = 1'b0;
        cnt_next = '0;
        if (rst_req_n_s) begin
          state_next = pwrseq_pkg::DEV_BOOT;
        end
      end
      default: begin
        state_next = pwrseq_pkg::DEV_OFF;
      end
    endcase
    // reset request from any powered state
    if (state_reg != pwrseq_pkg::DEV_OFF && !rst_req_n_s) begin
      state_next = pwrseq_pkg::DEV_RESET;
      ind_next = 1'b0;
      enum_next = 1'b0;
    end
    // placed after the reset branch so power-off wins
    // long reset, request released: off
    if (!rst_req_n_s && pon_n_s &&
        rst_cnt_reg == pwrseq_pkg::CNT_W'(EMERG_CYC)) begin
      state_next = pwrseq_pkg::DEV_OFF;
      ind_next = 1'b0;
    end
    // losing supply drops everything
    if (!supply_s) begin
      state_next = pwrseq_pkg::DEV_OFF;
      ind_next = 1'b0;
      enum_next = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pwrseq_pkg::DEV_OFF;
      cnt_reg <= '0;
      restart_reg <= 1'b0;
      ind_reg <= 1'b0;
      enum_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      restart_reg <= restart_next;
      ind_reg <= ind_next;
      enum_reg <= enum_next;
    end
  end

  // pin and user outputs
  assign pins.io_supply_indicator = ind_reg;
  assign pins.usb_enum_start = enum_reg;
  assign active = (state_reg == pwrseq_pkg::DEV_ACTIVE);
  assign booting = (state_reg == pwrseq_pkg::DEV_BOOT);
endmodule
`default_nettype wire

// [pwrseq_host.sv]
// Purpose: host-side driver of power-on, reset and powerdown pins
// Assumes: user requests are one-cycle pulses on clk
// Notes: device outputs are synchronised and only read while waiting on powerdown
`timescale 1ns/1ps
`default_nettype none
module pwrseq_host #(
  parameter int unsigned PRESS_CYC = pwrseq_pkg::PWR_ON_ASSERT_CYC,
  parameter int unsigned QUIET_CYC = pwrseq_pkg::HOST_QUIET_CYC,
  parameter int unsigned EMERG_CYC = pwrseq_pkg::EMERG_OFF_CYC,
  parameter bit HOLD_ON = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins toward the device
  pwrseq_if.host pins,
  // user requests
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic emergency_req,
  // user status
  output logic busy,
  output logic supply_on,
  output logic quiet_done
);
  logic [1:0] s1_reg, s2_reg;
  logic [1:0] s1_next, s2_next;
  pwrseq_pkg::host_state_t state_reg, state_next;
  logic [pwrseq_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic pon_n_reg, pon_n_next, rst_n_reg, rst_n_next;
  logic pd_reg, pd_next, sup_reg, sup_next, quiet_reg, quiet_next;

  // sync device outputs; only the indicator is used
  always_comb begin
    s1_next = {pins.usb_enum_start, pins.io_supply_indicator};
    s2_next = s1_reg;
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pon_n_next = pon_n_reg;
    rst_n_next = 1'b1;
    pd_next = 1'b0;
    sup_next = sup_reg;
    quiet_next = quiet_reg;
    unique case (state_reg)
      pwrseq_pkg::HOST_IDLE: begin
        if (power_up_req) begin
          sup_next = 1'b1;
          pon_n_next = 1'b0;
          cnt_next = '0;
          quiet_next = 1'b0;
          state_next = pwrseq_pkg::HOST_PRESS;
        end
      end
      pwrseq_pkg::HOST_PRESS: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= pwrseq_pkg::CNT_W'(PRESS_CYC - 1)) begin
          pon_n_next = ~HOLD_ON;
          state_next = pwrseq_pkg::HOST_WAIT;
        end
      end
      pwrseq_pkg::HOST_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= pwrseq_pkg::CNT_W'(QUIET_CYC - 1)) begin
          quiet_next = 1'b1;
          state_next = pwrseq_pkg::HOST_READY;
        end
      end
      pwrseq_pkg::HOST_READY: begin
        if (emergency_req) begin
          // a host that holds the request gets a plain reset
          // release request unless HOLD_ON, hold reset
          pon_n_next = ~HOLD_ON;
          rst_n_next = 1'b0;
          cnt_next = '0;
          state_next = pwrseq_pkg::HOST_EMERG;
        end else if (power_down_req) begin
          pd_next = 1'b1;
          state_next = pwrseq_pkg::HOST_PD_WAIT;
        end
      end
      pwrseq_pkg::HOST_PD_WAIT: begin
        if (!s2_reg[0] && !pd_reg) begin
          sup_next = pon_n_reg ? 1'b0 : sup_reg;
          state_next = pon_n_reg ? pwrseq_pkg::HOST_IDLE : pwrseq_pkg::HOST_WAIT;
          cnt_next = '0;
          quiet_next = 1'b0;
        end
      end
      pwrseq_pkg::HOST_EMERG: begin
        rst_n_next = 1'b0;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= pwrseq_pkg::CNT_W'(EMERG_CYC)) begin
          // supply kept: with the request released the module must power itself off
          rst_n_next = 1'b1;
          state_next = pwrseq_pkg::HOST_IDLE;
        end
      end
      default: begin
        state_next = pwrseq_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      state_reg <= pwrseq_pkg::HOST_IDLE;
      cnt_reg <= '0;
      pon_n_reg <= 1'b1;
      rst_n_reg <= 1'b1;
      pd_reg <= 1'b0;
      sup_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pon_n_reg <= pon_n_next;
      rst_n_reg <= rst_n_next;
      pd_reg <= pd_next;
      sup_reg <= sup_next;
      quiet_reg <= quiet_next;
    end
  end

  // pin drive and status
  assign pins.power_on_req_n = pon_n_reg;
  assign pins.reset_req_n = rst_n_reg;
  assign pins.powerdown_command = pd_reg;
  assign pins.baseband_battery_supply = sup_reg;
  assign busy = (state_reg != pwrseq_pkg::HOST_IDLE) && (state_reg != pwrseq_pkg::HOST_READY);
  assign supply_on = sup_reg;
  assign quiet_done = quiet_reg;
endmodule
`default_nettype wire

// [pwrseq_if.sv]
// Purpose: pins between host and module for power and reset control
// Assumes: single clock shared by both ends
// Notes: active-low pins idle high; supply presence is a level
`timescale 1ns/1ps
`default_nettype none
interface pwrseq_if;
  logic power_on_req_n;
  logic reset_req_n;
  logic powerdown_command;
  logic baseband_battery_supply;
  logic io_supply_indicator;
  logic usb_enum_start;
  modport device (
    input power_on_req_n, reset_req_n, powerdown_command, baseband_battery_supply,
    output io_supply_indicator, usb_enum_start
  );
  modport host (
    output power_on_req_n, reset_req_n, powerdown_command, baseband_battery_supply,
    input io_supply_indicator, usb_enum_start
  );
endinterface
`default_nettype wire

// [pwrseq_pkg.sv]
// Purpose: shared constants and types for the power on/off sequencer ends
// Assumes: 40 MHz clock; times in ms converted to cycles here
// Notes: long counts are overridden by module parameters in simulation
package pwrseq_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // host minimum power-on request hold, ms
  localparam int unsigned PWR_ON_ASSERT_MS = 200;
  localparam int unsigned PWR_ON_ASSERT_CYC = PWR_ON_ASSERT_MS * CYC_PER_MS;
  // host quiet period after power-on start, ms (strictly more than)
  localparam int unsigned HOST_QUIET_MS = 100;
  localparam int unsigned HOST_QUIET_CYC = HOST_QUIET_MS * CYC_PER_MS + 1;
  // power-on sequence typical and maximum, ms
  localparam int unsigned PWR_ON_TYP_MS = 15000;
  localparam int unsigned PWR_ON_TYP_CYC = PWR_ON_TYP_MS * CYC_PER_MS;
  localparam int unsigned PWR_ON_MAX_MS = 24000;
  localparam int unsigned PWR_ON_MAX_CYC = PWR_ON_MAX_MS * CYC_PER_MS;
  // emergency power-off reset hold, ms
  localparam int unsigned EMERG_OFF_MS = 8000;
  localparam int unsigned EMERG_OFF_CYC = EMERG_OFF_MS * CYC_PER_MS;
  // power-off sequence maximum, ms
  localparam int unsigned PWR_OFF_MAX_MS = 6000;
  localparam int unsigned PWR_OFF_MAX_CYC = PWR_OFF_MAX_MS * CYC_PER_MS;
  // reset pulse internal recovery, cycles
  localparam int unsigned RESET_RECOVER_CYC = 4;
  // pin synchroniser value after reset: {supply, powerdown, reset_n, power_on_n}
  localparam logic [3:0] PIN_IDLE = 4'h3;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0] {
    DEV_OFF, DEV_BOOT, DEV_ACTIVE, DEV_RESET, DEV_SHUTDOWN
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE, HOST_PRESS, HOST_WAIT, HOST_READY, HOST_PD_WAIT, HOST_EMERG
  } host_state_t;
endpackage

// [pwrseq_tb_top.sv]
// Purpose: self-checking bench joining host and module ends
// Assumes: shortened counts; pair b holds the power-on request
// Notes: pair a is watched by the checker
`timescale 1ns/1ps
`default_nettype none
module pwrseq_tb_top;
  localparam int unsigned BOOT = 50;
  localparam int unsigned BMAX = 60;
  localparam int unsigned OFFS = 20;
  localparam int unsigned EMRG = 30;
  localparam int unsigned PRESS = 10;
  localparam int unsigned QUIET = 10;
  logic clk, rst_n;
  logic [5:0] req;
  logic [1:0] busy, supply_on, quiet_done, active, booting, ind;
  int error_cnt, n_tests;
  int enum_cnt [2];
  pwrseq_if pins_a ();
  pwrseq_if pins_b ();
  assign ind = {pins_b.io_supply_indicator, pins_a.io_supply_indicator};

  // pair a releases the request, pair b holds it
  pwrseq_host #(.PRESS_CYC(PRESS), .QUIET_CYC(QUIET), .EMERG_CYC(EMRG), .HOLD_ON(1'b0))
    pwrseq_host_i (
    .clk(clk), .rst_n(rst_n), .pins(pins_a), .power_up_req(req[0]), .power_down_req(req[1]),
    .emergency_req(req[2]), .busy(busy[0]), .supply_on(supply_on[0]), .quiet_done(quiet_done[0]));
  pwrseq_device #(.BOOT_CYC(BOOT), .BOOT_MAX_CYC(BMAX), .EMERG_CYC(EMRG), .OFF_SEQ_CYC(OFFS))
    pwrseq_device_i (.clk(clk), .rst_n(rst_n), .pins(pins_a), .active(active[0]),
    .booting(booting[0]));
  pwrseq_host #(.PRESS_CYC(PRESS), .QUIET_CYC(QUIET), .EMERG_CYC(EMRG), .HOLD_ON(1'b1))
    pwrseq_host_b_i (
    .clk(clk), .rst_n(rst_n), .pins(pins_b), .power_up_req(req[3]), .power_down_req(req[4]),
    .emergency_req(req[5]), .busy(busy[1]), .supply_on(supply_on[1]), .quiet_done(quiet_done[1]));
  pwrseq_device #(.BOOT_CYC(BOOT), .BOOT_MAX_CYC(BMAX), .EMERG_CYC(EMRG), .OFF_SEQ_CYC(OFFS))
    pwrseq_device_b_i (.clk(clk), .rst_n(rst_n), .pins(pins_b), .active(active[1]),
    .booting(booting[1]));
  pwrseq_asserts #(.BOOT_MAX_CYC(BMAX), .OFF_SEQ_CYC(OFFS), .EMERG_CYC(EMRG), .PRESS_CYC(PRESS),
    .QUIET_CYC(QUIET)) pwrseq_asserts_i (.clk(clk), .rst_n(rst_n),
    .power_on_req_n(pins_a.power_on_req_n), .reset_req_n(pins_a.reset_req_n),
    .powerdown_command(pins_a.powerdown_command),
    .baseband_battery_supply(pins_a.baseband_battery_supply),
    .io_supply_indicator(pins_a.io_supply_indicator), .usb_enum_start(pins_a.usb_enum_start));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // enumeration pulse counts
  always @(posedge clk) begin
    if (pins_a.usb_enum_start === 1'b1) enum_cnt[0]++;
    if (pins_b.usb_enum_start === 1'b1) enum_cnt[1]++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic pulse(input int idx);
    @(posedge clk) req[idx] <= 1'b1;
    @(posedge clk) req[idx] <= 1'b0;
  endtask
  task automatic wait_ind(input int p, input logic lvl, output int n);
    n = 0;
    while (ind[p] !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wait_ready(input int p);
    int n;
    n = 0;
    while ((quiet_done[p] !== 1'b1 || busy[p] !== 1'b0) && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("host ready in time", 32'h1, 32'(n < 400));
  endtask
  task automatic t_power_on(input int p);
    int n, e0;
    e0 = enum_cnt[p];
    pulse(3 * p);
    wait_ind(p, 1'b1, n);
    check("boot time in range", 32'h1, 32'(n >= BOOT && n <= BMAX + 8));
    // the pulse is counted at the edge after the one that launches it
    @(negedge clk);
    check("enumeration pulses", 32'(e0 + 1), 32'(enum_cnt[p]));
    check("active after boot", 32'h1, {31'h0, active[p]});
    wait_ready(p);
  endtask
  task automatic t_pd_off();
    int n;
    pulse(1);
    wait_ind(0, 1'b0, n);
    check("off sequence time", 32'h1, 32'(n <= OFFS + 8));
    check("no reboot after off", 32'h0, {31'h0, booting[0]});
    repeat (BMAX + 10) @(negedge clk);
    check("stays off", 32'h0, {31'h0, ind[0]});
    check("supply removed", 32'h0, {31'h0, supply_on[0]});
  endtask
  task automatic t_emergency();
    int n;
    pulse(2);
    wait_ind(0, 1'b0, n);
    check("reset drops indicator", 32'h1, 32'(n <= 8));
    repeat (EMRG + BMAX + 20) @(negedge clk);
    check("emergency off indicator", 32'h0, {31'h0, ind[0]});
    check("emergency off active", 32'h0, {31'h0, active[0]});
  endtask
  task automatic t_restart();
    int n;
    pulse(4);
    wait_ind(1, 1'b0, n);
    check("restart drop time", 32'h1, 32'(n <= OFFS + 8));
    wait_ind(1, 1'b1, n);
    check("restart boot time", 32'h1, 32'(n <= BMAX + 8));
    wait_ready(1);
    pulse(5);
    wait_ind(1, 1'b0, n);
    check("reset drops indicator b", 32'h1, 32'(n <= 8));
    wait_ind(1, 1'b1, n);
    check("reboot after reset", 32'h1, 32'(n <= EMRG + BMAX + 12));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    req = 6'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_power_on(0);
    t_pd_off();
    t_power_on(0);
    t_emergency();
    t_power_on(1);
    t_restart();
    conclude();
  end
  // watchdog
  initial begin
    repeat (8000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
